// ### rtl/sbc_dev_port.sv
// one-access sequencer for the device's 8-bit register port
`timescale 1ns/1ps
module sbc_dev_port
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [2:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic reqDone,
  output logic [7:0] rdData,
  // device pins
  output logic [2:0] devAddr,
  output logic devCsN,
  output logic devRdN,
  output logic devWrN,
  input wire logic [7:0] devDataIn,
  output logic [7:0] devDataOut,
  output logic devDataOe
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} sbc_port_e;
  sbc_port_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic writing_q;
  logic [7:0] rdData_q;
  logic strobeEnd;

  assign strobeEnd = (cnt_q == CNT_W'(STROBE_CYC - 1));
  assign devCsN = (state_q == P_IDLE);
  assign devRdN = !((state_q == P_STROBE) && !writing_q);
  assign devWrN = !((state_q == P_STROBE) && writing_q);
  assign devDataOe = (state_q != P_IDLE) && writing_q;
  assign reqDone = (state_q == P_HOLD);
  assign rdData = rdData_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= P_IDLE;
      cnt_q <= '0;
      writing_q <= 1'b0;
      devAddr <= 3'h0;
      devDataOut <= 8'h00;
      rdData_q <= 8'h00;
    end else begin
      unique case (state_q)
        P_IDLE: begin
          if (reqValid) begin
            state_q <= P_SETUP;
            writing_q <= reqWrite;
            devAddr <= reqAddr;
            devDataOut <= reqData;
          end
        end
        P_SETUP: begin
          state_q <= P_STROBE;
          cnt_q <= '0;
        end
        P_STROBE: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (strobeEnd) begin
            state_q <= P_HOLD;
            // device read data is a pin input but stable well before strobe end
            if (!writing_q) begin
              rdData_q <= devDataIn;
            end
          end
        end
        P_HOLD: begin
          state_q <= P_IDLE;
          writing_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // sbc_dev_port

// ### rtl/sbc_host.sv
// host controller: apb registers in, device register sequencing out
// Behaviour
// RULE1 - set dma enable before start ports
// RULE2 - drive-data bit set for dma send
// RULE3 - role bit matches receive port written
// RULE4 - abort by clearing dma enable, no overlap
// RULE5 - load one id, set arbitrate, read flags (an id with more than one bit set is still loaded; only cmdErr is set)
// RULE6 - target command drives bus only as target
// RULE7 - phase encoding io cd msg
// RULE8 - initiator dma mismatch on req interrupts
// RULE9 - initiator send phase equals live lines
// RULE10 - top target command bit: last sent
// RULE11 - selection interrupt on masked id match
// RULE12 - end of dma flag on eop
// RULE13 - dma request bit mirrors pin
// RULE14 - parity flag cleared by clear port read
// RULE15 - interrupt bit equals irq pin
// RULE16 - phase match compares low three bits
// RULE17 - busy loss clears dma enable
// RULE18 - atn and ack at bits one, zero
// RULE19 - any start port write starts dma
// RULE20 - clear port read clears three flags
// RULE21 - bus free after 400 ns idle
// RULE22 - wait 2.2 us before arbitration check
// RULE23 - burst bit chooses byte end event
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module sbc_host
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device register port
  output logic [2:0] devAddr,
  output logic devCsN,
  output logic devRdN,
  output logic devWrN,
  input wire logic [7:0] devDataIn,
  output logic [7:0] devDataOut,
  output logic devDataOe,
  // device side-band pins
  input wire logic devIrq,
  input wire logic devDmaReq,
  // dma acknowledge, gated off during aborts
  input wire logic dmaAckIn,
  output logic dmaAckOut
);
  typedef enum logic [3:0] {
    S_IDLE, S_WR_MODE, S_WR_PHASE, S_WR_ICMD, S_WR_START, S_WR_ARBID, S_WR_ARB,
    S_ARB_WAIT, S_RD_ICMD, S_RD_BUS, S_RD_FLAGS, S_RD_CLEAR, S_WR_MASK
  } sbc_host_e;

  sbc_host_e state_q, state_d;
  logic [7:0] mode_q, phase_q, idMask_q, arbId_q;
  logic [7:0] busStat_q, flags_q, initCmd_q;
  logic [2:0] cmd_q;
  logic busy_q, cmdErr_q;
  logic [CNT_W-1:0] arbCnt_q;
  logic [2:0] irqSync_q, drqSync_q;
  logic irqPin, drqPin;
  logic irqPin_q, drqPin_q;
  logic reqValid, reqWrite, reqDone;
  logic [2:0] reqAddr;
  logic [7:0] reqData, rdData;
  logic apbAcc, apbWr, apbRd;
  logic wrCtrl, wrMode, wrPhase, wrMask, wrArbId;
  logic [2:0] newCmd;
  logic startCmd, roleOk, hasOneId, addrOk;
  logic [31:0] rdMux;

  function automatic logic oneHot(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign apbRd = apbAcc && !pwrite;
  assign pready = 1'b1;
  assign wrCtrl = apbWr && (paddr == A_CTRL);
  assign wrMode = apbWr && (paddr == A_MODE) && !busy_q;
  assign wrPhase = apbWr && (paddr == A_PHASE) && !busy_q;
  assign wrMask = apbWr && (paddr == A_IDMASK) && !busy_q;
  assign wrArbId = apbWr && (paddr == A_ARBID) && !busy_q;
  assign newCmd = pwdata[2:0];
  assign addrOk = (paddr == A_CTRL) || (paddr == A_MODE) || (paddr == A_PHASE) ||
                  (paddr == A_IDMASK) || (paddr == A_ARBID) || (paddr == A_STATUS) ||
                  (paddr == A_BUSSTAT) || (paddr == A_FLAGS) || (paddr == A_INITCMD);
  assign pslverr = apbAcc && !addrOk;
  assign irqPin = irqPin_q;
  assign drqPin = drqPin_q;
  // RULE3 role check
  assign roleOk = (cmd_q == CMD_TGT_RECV) ? mode_q[OC_TARGET] :
                  (cmd_q == CMD_INI_RECV) ? !mode_q[OC_TARGET] : 1'b1;
  // RULE5 one id only
  assign hasOneId = oneHot(arbId_q);
  assign startCmd = wrCtrl && !busy_q && (newCmd != 3'h0);
  // RULE23 dma_acknowledge passes through
  // RULE4 no dma_acknowledge to device while abort rewrites mode
  assign dmaAckOut = dmaAckIn && !(busy_q && (cmd_q == CMD_ABORT));

  always_comb begin
    unique case (paddr)
      A_CTRL: rdMux = {29'h0, cmd_q};
      A_MODE: rdMux = {24'h0, mode_q};
      A_PHASE: rdMux = {24'h0, phase_q};
      A_IDMASK: rdMux = {24'h0, idMask_q};
      A_ARBID: rdMux = {24'h0, arbId_q};
      A_STATUS: rdMux = {28'h0, drqPin, irqPin, cmdErr_q, busy_q};
      A_BUSSTAT: rdMux = {24'h0, busStat_q};
      A_FLAGS: rdMux = {24'h0, flags_q};
      A_INITCMD: rdMux = {24'h0, initCmd_q};
      default: rdMux = 32'h0;
    endcase
  end
  assign prdata = apbRd ? rdMux : 32'h0;

  // device access selection per state
  always_comb begin
    reqValid = 1'b1;
    reqWrite = 1'b1;
    reqAddr = DEV_OUT_DATA;
    reqData = 8'h00;
    unique case (state_q)
      S_WR_MODE: begin
        reqAddr = DEV_OPERATING_CONTROL;
        reqData = mode_q;
      end
      // RULE6 RULE7 target command
      S_WR_PHASE: begin
        reqAddr = DEV_TARGET_PHASE_COMMAND;
        reqData = phase_q;
      end
      // RULE2 drive data for send
      S_WR_ICMD: begin
        reqAddr = DEV_INIT_CMD;
        reqData = 8'h01 << IC_DRIVE_DATA;
      end
      // RULE19 data ignored on start
      S_WR_START: begin
        reqAddr = (cmd_q == CMD_SEND) ? DEV_BEGIN_OUTBOUND :
                  (cmd_q == CMD_TGT_RECV) ? DEV_BEGIN_TARGET_INBOUND :
                  DEV_BEGIN_INITIATOR_INBOUND;
        reqData = 8'h00;
      end
      S_WR_ARBID: begin
        reqAddr = DEV_OUT_DATA;
        reqData = arbId_q;
      end
      // RULE5 arbitrate bit
      S_WR_ARB: begin
        reqAddr = DEV_OPERATING_CONTROL;
        reqData = mode_q | (8'h01 << OC_ARBITRATE);
      end
      S_WR_MASK: begin
        reqAddr = DEV_SELECTION_ID_MASK;
        reqData = idMask_q;
      end
      S_RD_ICMD: begin
        reqWrite = 1'b0;
        reqAddr = DEV_INIT_CMD;
      end
      S_RD_BUS: begin
        reqWrite = 1'b0;
        reqAddr = DEV_LIVE_BUS_SIGNALS;
      end
      S_RD_FLAGS: begin
        reqWrite = 1'b0;
        reqAddr = DEV_TRANSFER_STATUS_FLAGS;
      end
      // RULE20 clear by read
      S_RD_CLEAR: begin
        reqWrite = 1'b0;
        reqAddr = DEV_FLAG_CLEAR_PORT;
      end
      default: begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
      end
    endcase
  end

  // sequence of device accesses per command
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (startCmd) begin
          unique case (newCmd)
            // RULE1 dma enable first
            CMD_SEND, CMD_TGT_RECV, CMD_INI_RECV: state_d = S_WR_MODE;
            CMD_ARBITRATE: state_d = S_WR_ARBID;
            CMD_ABORT: state_d = S_WR_MODE;
            CMD_CLEAR: state_d = S_RD_CLEAR;
            default: state_d = S_WR_MASK;
          endcase
        end
      end
      S_WR_MODE: begin
        if (reqDone) begin
          if (cmd_q == CMD_ABORT) state_d = S_RD_FLAGS;
          else if (!roleOk) state_d = S_IDLE;
          else state_d = S_WR_PHASE;
        end
      end
      S_WR_PHASE: begin
        if (reqDone) begin
          state_d = (cmd_q == CMD_SEND) ? S_WR_ICMD : S_WR_START;
        end
      end
      S_WR_ICMD: if (reqDone) state_d = S_WR_START;
      S_WR_START: if (reqDone) state_d = S_RD_FLAGS;
      S_WR_ARBID: if (reqDone) state_d = S_WR_ARB;
      S_WR_ARB: if (reqDone) state_d = S_ARB_WAIT;
      // RULE22 arbitration delay
      S_ARB_WAIT: if (arbCnt_q == CNT_W'(ARB_DELAY_CYC - 1)) state_d = S_RD_ICMD;
      S_RD_ICMD: if (reqDone) state_d = S_RD_BUS;
      S_WR_MASK: if (reqDone) state_d = S_RD_BUS;
      S_RD_BUS: if (reqDone) state_d = S_RD_FLAGS;
      S_RD_CLEAR: if (reqDone) state_d = S_RD_FLAGS;
      S_RD_FLAGS: if (reqDone) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      irqSync_q <= 3'h0;
      drqSync_q <= 3'h0;
      irqPin_q <= 1'b0;
      drqPin_q <= 1'b0;
      arbCnt_q <= '0;
    end else begin
      state_q <= state_d;
      irqSync_q <= {irqSync_q[1:0], devIrq};
      drqSync_q <= {drqSync_q[1:0], devDmaReq};
      // a pin change counts only once the last two stages agree
      if (irqSync_q[2] == irqSync_q[1]) irqPin_q <= irqSync_q[2];
      if (drqSync_q[2] == drqSync_q[1]) drqPin_q <= drqSync_q[2];
      arbCnt_q <= (state_q == S_ARB_WAIT) ? arbCnt_q + CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 8'h00;
      phase_q <= 8'h00;
      idMask_q <= 8'h00;
      arbId_q <= 8'h00;
      cmd_q <= 3'h0;
      busy_q <= 1'b0;
      cmdErr_q <= 1'b0;
    end else begin
      if (wrMode) mode_q <= pwdata[7:0];
      // RULE9 phase bits from software
      if (wrPhase) phase_q <= pwdata[7:0];
      if (wrMask) idMask_q <= pwdata[7:0];
      if (wrArbId) arbId_q <= pwdata[7:0];
      if (startCmd) begin
        cmd_q <= newCmd;
        busy_q <= 1'b1;
        cmdErr_q <= 1'b0;
        // RULE1 dma enable for starts
        if ((newCmd == CMD_SEND) || (newCmd == CMD_TGT_RECV) || (newCmd == CMD_INI_RECV)) begin
          mode_q[OC_DMA_EN] <= 1'b1;
        end
        // RULE4 abort clears enable
        if (newCmd == CMD_ABORT) mode_q[OC_DMA_EN] <= 1'b0;
        if ((newCmd == CMD_ARBITRATE) && !hasOneId) cmdErr_q <= 1'b1;
      end else if (busy_q && (state_d == S_IDLE)) begin
        busy_q <= 1'b0;
        if ((state_q == S_WR_MODE) && !roleOk) cmdErr_q <= 1'b1;
      end
      // RULE17 busy loss dropped enable in device
      if ((state_q == S_RD_FLAGS) && reqDone && rdData[TS_BUSY_ERR]) begin
        mode_q[OC_DMA_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busStat_q <= 8'h00;
      flags_q <= 8'h00;
      initCmd_q <= 8'h00;
    end else if (reqDone) begin
      if (state_q == S_RD_BUS) busStat_q <= rdData;
      // RULE18 atn ack bits kept as read
      if (state_q == S_RD_FLAGS) flags_q <= rdData;
      // RULE5 arbitration result flags
      if (state_q == S_RD_ICMD) initCmd_q <= rdData;
    end
  end

  sbc_dev_port u_port (
    .clock(clock),
    .nrst(nrst),
    .reqValid(reqValid),
    .reqWrite(reqWrite),
    .reqAddr(reqAddr),
    .reqData(reqData),
    .reqDone(reqDone),
    .rdData(rdData),
    .devAddr(devAddr),
    .devCsN(devCsN),
    .devRdN(devRdN),
    .devWrN(devWrN),
    .devDataIn(devDataIn),
    .devDataOut(devDataOut),
    .devDataOe(devDataOe)
  );
endmodule // sbc_host

// ### rtl/sbc_pkg.sv
// package for the scsi bus controller host: device map, bit layout, timing
package sbc_pkg;
  // device register ports (3-bit chip address)
  localparam logic [2:0] DEV_OUT_DATA = 3'h0;
  localparam logic [2:0] DEV_INIT_CMD = 3'h1;
  localparam logic [2:0] DEV_OPERATING_CONTROL = 3'h2;
  localparam logic [2:0] DEV_TARGET_PHASE_COMMAND = 3'h3;
  localparam logic [2:0] DEV_LIVE_BUS_SIGNALS = 3'h4;
  localparam logic [2:0] DEV_SELECTION_ID_MASK = 3'h4;
  localparam logic [2:0] DEV_TRANSFER_STATUS_FLAGS = 3'h5;
  localparam logic [2:0] DEV_BEGIN_OUTBOUND = 3'h5;
  localparam logic [2:0] DEV_BEGIN_TARGET_INBOUND = 3'h6;
  localparam logic [2:0] DEV_BEGIN_INITIATOR_INBOUND = 3'h7;
  localparam logic [2:0] DEV_FLAG_CLEAR_PORT = 3'h7;
  // operating_control bits
  localparam int OC_BURST = 7;
  localparam int OC_TARGET = 6;
  localparam int OC_PAR_CHECK = 5;
  localparam int OC_PAR_IRQ = 4;
  localparam int OC_EOP_IRQ = 3;
  localparam int OC_MON_BUSY = 2;
  localparam int OC_DMA_EN = 1;
  localparam int OC_ARBITRATE = 0;
  // initiator command bits
  localparam int IC_DRIVE_DATA = 0;
  localparam int IC_ARB_IN_PROGRESS = 6;
  localparam int IC_LOST_ARB = 5;
  // target_phase_command bits
  localparam int TP_LAST_SENT = 7;
  localparam int TP_ASSERT_REQ = 3;
  localparam int TP_PHASE_LSB = 0;
  localparam int TP_PHASE_W = 3;
  // transfer_status_flags bits
  localparam int TS_END_DMA = 7;
  localparam int TS_DMA_REQ = 6;
  localparam int TS_PAR_ERR = 5;
  localparam int TS_IRQ = 4;
  localparam int TS_PHASE_MATCH = 3;
  localparam int TS_BUSY_ERR = 2;
  localparam int TS_ATN = 1;
  localparam int TS_ACK = 0;
  // live_bus_signals: phase field bits 4..2 are msg, c/d, i/o
  localparam int LB_IO = 2;
  localparam int LB_CD = 3;
  localparam int LB_MSG = 4;
  // phase encoding {i/o, c/d, msg}
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_COMMAND = 3'h2;
  localparam logic [2:0] PH_MSG_OUT = 3'h3;
  localparam logic [2:0] PH_DATA_IN = 3'h4;
  localparam logic [2:0] PH_STATUS = 3'h6;
  localparam logic [2:0] PH_MSG_IN = 3'h7;
  // own apb register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_PHASE = 8'h08;
  localparam logic [7:0] A_IDMASK = 8'h0c;
  localparam logic [7:0] A_ARBID = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_BUSSTAT = 8'h18;
  localparam logic [7:0] A_FLAGS = 8'h1c;
  localparam logic [7:0] A_INITCMD = 8'h20;
  // ctrl command codes written to A_CTRL
  localparam logic [2:0] CMD_SEND = 3'h1;
  localparam logic [2:0] CMD_TGT_RECV = 3'h2;
  localparam logic [2:0] CMD_INI_RECV = 3'h3;
  localparam logic [2:0] CMD_ARBITRATE = 3'h4;
  localparam logic [2:0] CMD_ABORT = 3'h5;
  localparam logic [2:0] CMD_CLEAR = 3'h6;
  localparam logic [2:0] CMD_REFRESH = 3'h7;
  // timing (20 MHz clock)
  localparam int CLK_MHZ = 20;
  localparam int ARB_DELAY_NS = 2200;
  localparam int ARB_DELAY_CYC = (ARB_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS = 150;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 7;
endpackage

// ### tb/sbc_dev_model.sv
// behavioural model of the scsi protocol device behind the host
`timescale 1ns/1ps
module sbc_dev_model
  import sbc_pkg::*;
(
  // register port
  input wire logic [2:0] devAddr,
  input wire logic devCsN,
  input wire logic devRdN,
  input wire logic devWrN,
  input wire logic [7:0] devDataOut,
  output logic [7:0] devDataIn,
  // side-band pins
  input wire logic dmaAck,
  output logic devIrq,
  output logic devDmaReq,
  // scsi lines as the device sees them
  input wire logic bsy,
  input wire logic atn,
  input wire logic ack,
  input wire logic [2:0] phase
);
  logic [7:0] mode_q = 8'h00;
  logic [7:0] tcmd_q = 8'h00;
  logic [7:0] icmd_q = 8'h00;
  logic [7:0] rd_q = 8'h00;
  logic busyErr_q = 1'b0;
  realtime idleAt = 0;
  initial devIrq = 1'b0;
  initial devDmaReq = 1'b0;
  // released bus shows the inverse, so a stale sample cannot pass
  assign devDataIn = (!devCsN && !devRdN) ? rd_q : ~rd_q;
  always @(bsy) idleAt = $realtime;
  always @(negedge devRdN) begin
    case (devAddr)
      DEV_INIT_CMD: rd_q = {1'b0, mode_q[OC_ARBITRATE] && !bsy && ($realtime - idleAt >= 400),
        1'b0, icmd_q[4:0]};
      DEV_OPERATING_CONTROL: rd_q = mode_q;
      DEV_TARGET_PHASE_COMMAND: rd_q = tcmd_q;
      DEV_LIVE_BUS_SIGNALS: rd_q = {1'b0, bsy, 1'b0, phase[0], phase[1], phase[2], 2'b00};
      // sources absent, read zero
      // command holds i/o in bit 0, msg in bit 2; phase lines are {i/o, c/d, msg}
      DEV_TRANSFER_STATUS_FLAGS: rd_q = {1'b0, devDmaReq, 1'b0, devIrq,
        phase == {tcmd_q[0], tcmd_q[1], tcmd_q[2]}, busyErr_q, atn, ack};
      default: rd_q = ~rd_q;
    endcase
  end
  always @(posedge devRdN) begin
    if (!devCsN && devAddr == DEV_FLAG_CLEAR_PORT) begin
      devIrq = 1'b0;
      busyErr_q = 1'b0;
    end
  end
  always @(posedge devWrN) begin
    if (!devCsN) begin
      case (devAddr)
        DEV_INIT_CMD: icmd_q = devDataOut;
        DEV_OPERATING_CONTROL: mode_q = devDataOut;
        DEV_TARGET_PHASE_COMMAND: tcmd_q = devDataOut;
        DEV_BEGIN_OUTBOUND, DEV_BEGIN_TARGET_INBOUND, DEV_BEGIN_INITIATOR_INBOUND: devDmaReq = 1'b1;
        default: ;
      endcase
    end
  end
  always @(dmaAck or mode_q) begin
    if (dmaAck || !mode_q[OC_DMA_EN])
      devDmaReq = 1'b0;
  end
  always @(negedge bsy) begin
    if (mode_q[OC_MON_BUSY]) begin
      busyErr_q = 1'b1;
      devIrq = 1'b1;
      mode_q[OC_DMA_EN] = 1'b0;
    end
  end
endmodule // sbc_dev_model

// ### tb/sbc_host_properties.sv
// concurrent checks on the host controller's apb and device-port pins
`timescale 1ns/1ps
module sbc_host_properties
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device port
  input wire logic [2:0] devAddr,
  input wire logic devCsN,
  input wire logic devRdN,
  input wire logic devWrN,
  input wire logic [7:0] devDataOut,
  input wire logic devDataOe,
  input wire logic dmaAckIn,
  input wire logic dmaAckOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [7:0] mode_q;
  logic [7:0] icmd_q;
  logic [CNT_W-1:0] arbAge_q;
  wire apbAcc = psel && penable;
  wire mapped = paddr[1:0] == 2'b00 && paddr <= A_INITCMD;
  wire devWrite = !devCsN && !devWrN;
  wire modeWrite = devWrite && devAddr == DEV_OPERATING_CONTROL;
  // age saturates so reads long after any arbitration stay legal
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 8'h00;
      icmd_q <= 8'h00;
      arbAge_q <= '1;
    end else begin
      if (modeWrite)
        mode_q <= devDataOut;
      if (devWrite && devAddr == DEV_INIT_CMD)
        icmd_q <= devDataOut;
      if (modeWrite && devDataOut[OC_ARBITRATE])
        arbAge_q <= '0;
      else if (arbAge_q != '1)
        arbAge_q <= arbAge_q + 1'b1;
    end
  end
  a_start_dma_enabled: assert property (devWrite && devAddr >= DEV_BEGIN_OUTBOUND
    |-> mode_q[OC_DMA_EN]) else $error("start port written with dma disabled");
  a_send_drives_bus: assert property (devWrite && devAddr == DEV_BEGIN_OUTBOUND
    |-> icmd_q[IC_DRIVE_DATA]) else $error("send started without data drive");
  a_target_port_role: assert property (devWrite && devAddr == DEV_BEGIN_TARGET_INBOUND
    |-> mode_q[OC_TARGET]) else $error("target receive started as initiator");
  a_init_port_role: assert property (devWrite && devAddr == DEV_BEGIN_INITIATOR_INBOUND
    |-> !mode_q[OC_TARGET]) else $error("initiator receive started as target");
  a_abort_ack_gated: assert property (modeWrite && !devDataOut[OC_DMA_EN]
    |-> !dmaAckOut) else $error("dma ack passed while dma mode cleared");
  a_arb_delay_kept: assert property (!devCsN && !devRdN && devAddr == DEV_INIT_CMD
    |-> arbAge_q >= ARB_DELAY_CYC) else $error("arbitration result read too early");
  a_write_strobe_len: assert property ($fell(devWrN) |-> !devWrN [*3] ##1 devWrN)
    else $error("write strobe width wrong");
  a_read_strobe_len: assert property ($fell(devRdN) |-> !devRdN [*3] ##1 devRdN)
    else $error("read strobe width wrong");
  a_write_drives_bus: assert property (!devWrN |-> devDataOe && !devCsN && devRdN)
    else $error("write strobe without drive or select");
  a_read_bus_free: assert property (!devRdN |-> !devDataOe && !devCsN)
    else $error("read strobe while driving data");
  a_slverr_unmapped: assert property (apbAcc |-> pready && pslverr == !mapped)
    else $error("apb error response wrong");
  a_rdata_idle: assert property (!(apbAcc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
endmodule // sbc_host_properties

// ### tb/sbc_host_test.sv
// self-checking bench for the scsi bus host controller
`timescale 1ns/1ps
module sbc_host_test
  import sbc_pkg::*;
;
  typedef struct {logic [32:0] v; logic [32:0] m; string n;} sbc_note_s;
  localparam logic [2:0] PHS [6] = '{PH_DATA_OUT, PH_COMMAND, PH_MSG_OUT, PH_DATA_IN,
    PH_STATUS, PH_MSG_IN};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dmaAckIn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, devCsN, devRdN, devWrN, devDataOe, devIrq, devDmaReq, dmaAckOut;
  logic [2:0] devAddr;
  logic [7:0] devDataIn, devDataOut, r8;
  logic bsy = 1'b1;
  logic atn = 1'b0;
  logic ack = 1'b0;
  logic [2:0] phase = 3'h0;
  integer seed = 92824;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  sbc_note_s notes[$];
  sbc_note_s note;
  always #25 clock = ~clock;
  sbc_host dut_u (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .devAddr(devAddr), .devCsN(devCsN), .devRdN(devRdN), .devWrN(devWrN),
    .devDataIn(devDataIn), .devDataOut(devDataOut), .devDataOe(devDataOe), .devIrq(devIrq),
    .devDmaReq(devDmaReq), .dmaAckIn(dmaAckIn), .dmaAckOut(dmaAckOut));
  sbc_dev_model dev_u (.devAddr(devAddr), .devCsN(devCsN), .devRdN(devRdN), .devWrN(devWrN),
    .devDataOut(devDataOut), .devDataIn(devDataIn), .dmaAck(dmaAckOut), .devIrq(devIrq),
    .devDmaReq(devDmaReq), .bsy(bsy), .atn(atn), .ack(ack), .phase(phase));
  task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_rd(input string n, input logic [7:0] a, input logic [32:0] v,
    input logic [32:0] m);
    notes.push_back('{v, m, n});
    apb(1'b0, a, 32'h0);
  endtask
  // polls carry an empty mask, so the monitor skips them
  task automatic cmd(input logic [2:0] c);
    int n = 0;
    apb(1'b1, A_CTRL, {29'h0, c});
    do begin
      expect_rd("poll", A_STATUS, 33'h0, 33'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (rd[0] !== 1'b0) fail_count++;
  endtask
  function automatic logic [32:0] flags(input logic dma_request_pin, input logic irq, input logic be,
    input logic [2:0] tp);
    return {25'h0, 1'b0, dma_request_pin, 1'b0, irq, phase == tp, be, atn, ack};
  endfunction
  always @(posedge clock) begin
    cycles++;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      note = notes.pop_front();
      if (note.m !== 33'h0)
        check(note.n, {pslverr, prdata} & note.m, note.v & note.m);
    end
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 1; i < 5; i++) begin
      r8 = 8'($random(seed));
      apb(1'b1, 8'(4 * i), {24'hffffff, r8});
      expect_rd("reg", 8'(4 * i), {25'h0, r8}, '1);
    end
    apb(1'b1, 8'h28, 32'h0);
    expect_rd("unmapped", 8'h24, {1'b1, 32'h0}, '1);
    $display("test registers done");
    apb(1'b1, A_MODE, 32'h0);
    foreach (PHS[i]) begin
      phase <= PHS[i] ^ {2'b00, i[0]};
      atn <= 1'($random(seed));
      ack <= 1'($random(seed));
      apb(1'b1, A_PHASE, {29'h0, PHS[i][0], PHS[i][1], PHS[i][2]});
      cmd(CMD_SEND);
      expect_rd("flags", A_FLAGS, flags(1'b1, 1'b0, 1'b0, PHS[i]), 33'hff);
      cmd(CMD_REFRESH);
      expect_rd("bus", A_BUSSTAT, {27'h0, phase[0], phase[1], phase[2], 2'b00}, 33'h1c);
    end
    expect_rd("status", A_STATUS, 33'h8, 33'hf);
    $display("test send phases done");
    apb(1'b1, A_MODE, 32'h40);
    cmd(CMD_TGT_RECV);
    expect_rd("status", A_STATUS, 33'h0, 33'h3);
    cmd(CMD_INI_RECV);
    expect_rd("status", A_STATUS, 33'h2, 33'h3);
    apb(1'b1, A_MODE, 32'h0);
    cmd(CMD_TGT_RECV);
    expect_rd("status", A_STATUS, 33'h2, 33'h3);
    $display("test role ports done");
    cmd(CMD_SEND);
    cmd(CMD_ABORT);
    expect_rd("flags", A_FLAGS, 33'h0, 33'h40);
    cmd(CMD_SEND);
    dmaAckIn <= 1'b1;
    repeat (3) @(posedge clock);
    dmaAckIn <= 1'b0;
    cmd(CMD_CLEAR);
    expect_rd("flags", A_FLAGS, 33'h0, 33'h40);
    dmaAckIn <= 1'b1;
    cmd(CMD_ABORT);
    dmaAckIn <= 1'b0;
    $display("test abort done");
    apb(1'b1, A_MODE, 32'h04);
    cmd(CMD_SEND);
    bsy <= 1'b0;
    cmd(CMD_REFRESH);
    expect_rd("mode", A_MODE, 33'h4, 33'h6);
    cmd(CMD_ABORT);
    expect_rd("flags", A_FLAGS, 33'h14, 33'h14);
    cmd(CMD_CLEAR);
    expect_rd("flags", A_FLAGS, 33'h0, 33'h34);
    expect_rd("status", A_STATUS, 33'h0, 33'h4);
    $display("test busy loss done");
    apb(1'b1, A_MODE, 32'h0);
    apb(1'b1, A_ARBID, 32'h04);
    cmd(CMD_ARBITRATE);
    expect_rd("initcmd", A_INITCMD, 33'h40, 33'h40);
    expect_rd("status", A_STATUS, 33'h0, 33'h2);
    apb(1'b1, A_ARBID, 32'h06);
    cmd(CMD_ARBITRATE);
    expect_rd("status", A_STATUS, 33'h2, 33'h2);
    bsy <= 1'b1;
    apb(1'b1, A_ARBID, 32'h01);
    cmd(CMD_ARBITRATE);
    expect_rd("initcmd", A_INITCMD, 33'h0, 33'h40);
    $display("test arbitration done");
    repeat (2) @(posedge clock);
    wrap_up();
  end
endmodule // sbc_host_test
bind sbc_host sbc_host_properties chk_u (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .devAddr(devAddr), .devCsN(devCsN), .devRdN(devRdN), .devWrN(devWrN),
  .devDataOut(devDataOut), .devDataOe(devDataOe), .dmaAckIn(dmaAckIn), .dmaAckOut(dmaAckOut));
